//--- verif/uie_top_tb.sv
// Purpose: self-checking bench for the rx and bus-event irq enables
// Assumes: zero-wait apb slave, short frame timeout for simulation
// Notes:   bench model holds enables as integers
`timescale 1ns/1ps
module uie_top_tb;
   import uie_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, er;
   logic  [3:1] rx_pending;
   logic        frame_token, frame_expected, bus_reset_evt, resume_evt, suspend_evt;
   logic        rx_irq, bus_irq, irq_req, irq;
   int          err_count, cmp_count, cyc, seed, rx_en, bus_en, k, v;
   uie_top #(.FRAME_TIMEOUT(50)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pending(rx_pending),
      .frame_token(frame_token), .frame_expected(frame_expected),
      .bus_reset_evt(bus_reset_evt), .resume_evt(resume_evt),
      .suspend_evt(suspend_evt), .rx_irq(rx_irq), .bus_irq(bus_irq),
      .irq_req(irq_req), .irq(irq));
   initial begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count = err_count + 1;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   // one apb transfer, waits for pready at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input int b);
      @(posedge pclk);
      frame_token   <= (b == 3);
      bus_reset_evt <= (b == 2);
      resume_evt    <= (b == 1);
      suspend_evt   <= (b == 0);
      @(posedge pclk);
      {frame_token, bus_reset_evt, resume_evt, suspend_evt} <= 4'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {frame_token, frame_expected, bus_reset_evt, resume_evt, suspend_evt} = '0;
      rx_pending = 3'h0;
      err_count = 0;
      cmp_count = 0;
      cyc = 0;
      seed = 20414;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rx_en = 'h0e;
      bus_en = 'h06;
      apb(0, ba(RX_EN_IDX), 0);  chk(rd, rx_en);
      apb(0, ba(BUS_EN_IDX), 0); chk(rd, bus_en);
      apb(1, ba(RX_EN_IDX), 32'hffffffff);  chk(er, 0);
      rx_en = 32'hffffffff & 'h0e;
      apb(0, ba(RX_EN_IDX), 0);  chk(rd, rx_en);
      apb(1, ba(BUS_EN_IDX), 32'hffffffff);
      bus_en = 32'hffffffff & 'h0f;
      apb(0, ba(BUS_EN_IDX), 0); chk(rd, bus_en);
      apb(0, 12'hffc, 0);        chk(er, 1);
      $display("test registers done");
      for (k = 0; k < 12; k++) begin
         v = $random(seed);
         rx_en = v & 'h0e;
         apb(1, ba(RX_EN_IDX), v);
         @(posedge pclk);
         rx_pending <= v[7:5];
         repeat (3) @(posedge pclk);
         chk(rx_irq, ((v >> 4) & rx_en) != 0);
         chk(irq_req, ((v >> 4) & rx_en) != 0);
      end
      rx_pending <= 3'h0;
      $display("test rx masking done");
      for (k = 0; k < 8; k++) begin
         v = $random(seed);
         bus_en = v & 'h0f;
         apb(1, ba(BUS_EN_IDX), v);
         pulse(k % 4);
         repeat (3) @(posedge pclk);
         chk(bus_irq, bus_en[k % 4]);
         chk(irq_req, bus_en[k % 4]);
         apb(0, ba(BUS_STAT_IDX), 0); chk(rd, 1 << (k % 4));
         apb(0, ba(BUS_STAT_IDX), 0); chk(rd, 0);
         repeat (3) @(posedge pclk);
         chk(bus_irq, 0);
      end
      fork
         apb(0, ba(BUS_STAT_IDX), 0);
         begin
            repeat (2) @(posedge pclk);
            suspend_evt <= 1'b1;
            @(posedge pclk);
            suspend_evt <= 1'b0;
         end
      join
      chk(rd, 0);
      apb(0, ba(BUS_STAT_IDX), 0); chk(rd, 32'h1);
      apb(0, ba(BUS_STAT_IDX), 0); chk(rd, 0);
      $display("test bus events done");
      frame_expected <= 1'b1;
      repeat (60) @(posedge pclk);
      frame_expected <= 1'b0;
      apb(0, ba(BUS_STAT_IDX), 0); chk(rd, 32'h08);
      $display("test missed frame done");
      apb(1, ba(RX_EN_IDX), 32'h02);
      apb(1, ba(IRQ_MASK_IDX), 32'h3);
      apb(1, ba(IRQ_STAT_IDX), 32'h3);
      repeat (3) @(posedge pclk);
      chk(irq, 0);
      rx_pending <= 3'h1;
      repeat (5) @(posedge pclk);
      chk(irq, 1);
      apb(0, ba(IRQ_STAT_IDX), 0); chk(rd, 32'h1);
      apb(1, ba(IRQ_STAT_IDX), 32'h1);
      repeat (3) @(posedge pclk);
      chk(irq, 0);
      chk(irq_req, 1);
      rx_pending <= 3'h0;
      apb(1, ba(IRQ_MASK_IDX), 32'h0);
      repeat (2) @(posedge pclk);
      rx_pending <= 3'h1;
      repeat (5) @(posedge pclk);
      chk(irq, 0);
      $display("test irq status and mask done");
      report_and_stop();
   end
endmodule

//--- verilog/uie_flags.sv
// Purpose: sticky pending flags for the bus-level events
// Assumes: event inputs are one-cycle pulses synchronous to pclk
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module uie_flags
   import uie_pkg::*;
#(
   parameter int FRAME_TIMEOUT = FRAME_CYCLES + FRAME_SLACK
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       frame_token,
   input  wire logic       frame_expected,
   input  wire logic       bus_reset_evt,
   input  wire logic       resume_evt,
   input  wire logic       suspend_evt,
   input  wire logic       clear_rd,
   output logic      [3:0] pend
);
   logic [31:0] frame_cnt;
   logic        synth_frame;
   logic [3:0]  set_vec;

   assign synth_frame = frame_expected && (frame_cnt >= 32'(FRAME_TIMEOUT));
   always_comb begin
      set_vec = 4'h0;
      set_vec[FRAME_START_BIT] = frame_token | synth_frame;
      set_vec[BUS_RESET_BIT]   = bus_reset_evt;
      set_vec[RESUME_BIT]      = resume_evt;
      set_vec[SUSPEND_BIT]     = suspend_evt;
   end

   ////////////////////////////////////////////////////////////////////
   // missed frame watchdog
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_cnt <= 32'h0;
      end else if (frame_token || synth_frame || !frame_expected) begin
         frame_cnt <= 32'h0;
      end else begin
         frame_cnt <= frame_cnt + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 4'h0;
      end else begin
         pend <= (clear_rd ? 4'h0 : pend) | set_vec;
      end
   end

   a_synth_frame_sets: assert property (@(posedge pclk) disable iff (!presetn)
      synth_frame |=> pend[FRAME_START_BIT])
      else $error("synthesized frame start did not set flag");
   a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (clear_rd && set_vec == 4'h0) |=> pend == 4'h0)
      else $error("status read did not clear flags");
endmodule

//--- verilog/uie_pkg.sv
// Purpose: constants for the receive and bus-event interrupt enable block
// Assumes: APB with 32-bit data; registers at printed index times four
// Notes:   one package shared by the top and the pending-flag module
package uie_pkg;
   // register indices as printed, byte address is index times four
   localparam logic [7:0]  RX_EN_IDX       = 8'h09;
   localparam logic [7:0]  BUS_EN_IDX      = 8'h0b;
   localparam logic [7:0]  BUS_STAT_IDX    = 8'h06;
   localparam logic [7:0]  RX_STAT_IDX     = 8'h0c;
   localparam logic [7:0]  IRQ_STAT_IDX    = 8'h0d;
   localparam logic [7:0]  IRQ_MASK_IDX    = 8'h0e;
   localparam logic [7:0]  RX_EN_RESET     = 8'h0e;
   localparam logic [7:0]  BUS_EN_RESET    = 8'h06;
   localparam logic [7:0]  RX_EN_WMASK     = 8'h0e;
   localparam logic [7:0]  BUS_EN_WMASK    = 8'h0f;
   // bus event field positions
   localparam int          SUSPEND_BIT     = 0;
   localparam int          RESUME_BIT      = 1;
   localparam int          BUS_RESET_BIT   = 2;
   localparam int          FRAME_START_BIT = 3;
   // irq status bits: 0 receive request, 1 bus-event request
   localparam logic [1:0]  IRQ_MASK_RESET  = 2'h0;
   // frame period and watchdog slack
   localparam int          FRAME_US        = 1000;
   localparam int          CLK_MHZ         = 200;
   localparam int          FRAME_CYCLES    = FRAME_US * CLK_MHZ;
   localparam int          FRAME_SLACK     = 2000;

   function automatic logic [9:0] word_index(input logic [11:0] addr);
      return addr[11:2];
   endfunction
endpackage

//--- verilog/uie_top.sv
// Purpose: receive and bus-event interrupt enables with APB access
// Assumes: pclk 200 MHz; rx pending flags held outside
// Notes:   reads of bus-event status clear those flags
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module uie_top
   import uie_pkg::*;
#(
   parameter int FRAME_TIMEOUT = FRAME_CYCLES + FRAME_SLACK
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic  [3:1] rx_pending,
   input  wire logic        frame_token,
   input  wire logic        frame_expected,
   input  wire logic        bus_reset_evt,
   input  wire logic        resume_evt,
   input  wire logic        suspend_evt,
   output logic             rx_irq,
   output logic             bus_irq,
   output logic             irq_req,
   output logic             irq
);
   logic [7:0]  rx_en;
   logic [7:0]  bus_en;
   logic [1:0]  irq_stat;
   logic [1:0]  irq_mask;
   logic [3:0]  bus_pend;
   logic [3:0]  rx_terms;
   logic [3:0]  bus_terms;
   logic        access;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic        clear_rd;
   logic [9:0]  idx;
   logic [1:0]  rise;
   logic [1:0]  prev_req;
   logic [31:0] next_prdata;

   ////////////////////////////////////////////////////////////////////
   // apb decode, zero wait state
   assign access = psel && penable;
   assign idx    = word_index(paddr);
   assign wr     = access && pwrite;
   assign rd     = access && !pwrite;
   assign pready = 1'b1;
   assign mapped = idx == 10'(RX_EN_IDX) || idx == 10'(BUS_EN_IDX)
                || idx == 10'(BUS_STAT_IDX) || idx == 10'(RX_STAT_IDX)
                || idx == 10'(IRQ_STAT_IDX) || idx == 10'(IRQ_MASK_IDX);
   assign pslverr  = access && !mapped;
   assign clear_rd = rd && idx == 10'(BUS_STAT_IDX);

   ////////////////////////////////////////////////////////////////////
   // enable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_en <= RX_EN_RESET;
      end else if (wr && idx == 10'(RX_EN_IDX)) begin
         rx_en <= pwdata[7:0] & RX_EN_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_en <= BUS_EN_RESET;
      end else if (wr && idx == 10'(BUS_EN_IDX)) begin
         bus_en <= pwdata[7:0] & BUS_EN_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= IRQ_MASK_RESET;
      end else if (wr && idx == 10'(IRQ_MASK_IDX)) begin
         irq_mask <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pending flags
   uie_flags #(
      .FRAME_TIMEOUT (FRAME_TIMEOUT)
   ) u_flags (
      .pclk           (pclk),
      .presetn        (presetn),
      .frame_token    (frame_token),
      .frame_expected (frame_expected),
      .bus_reset_evt  (bus_reset_evt),
      .resume_evt     (resume_evt),
      .suspend_evt    (suspend_evt),
      .clear_rd       (clear_rd),
      .pend           (bus_pend)
   );

   ////////////////////////////////////////////////////////////////////
   // masking
   assign rx_terms  = {rx_pending, 1'b0} & rx_en[3:0];
   assign bus_terms = bus_pend & bus_en[3:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_irq  <= 1'b0;
         bus_irq <= 1'b0;
         irq_req <= 1'b0;
      end else begin
         rx_irq  <= |rx_terms;
         bus_irq <= |bus_terms;
         irq_req <= |{rx_terms, bus_terms};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sticky irq status, write one to clear, set wins
   assign rise = {bus_irq, rx_irq} & ~prev_req;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_req <= 2'h0;
      end else begin
         prev_req <= {bus_irq, rx_irq};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 2'h0;
      end else if (wr && idx == 10'(IRQ_STAT_IDX)) begin
         irq_stat <= (irq_stat & ~pwdata[1:0]) | rise;
      end else begin
         irq_stat <= irq_stat | rise;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data
   always_comb begin
      next_prdata = 32'h0;
      if (rd) begin
         if (idx == 10'(RX_EN_IDX)) begin
            next_prdata = {24'h0, rx_en & RX_EN_WMASK};
         end else if (idx == 10'(BUS_EN_IDX)) begin
            next_prdata = {24'h0, bus_en & BUS_EN_WMASK};
         end else if (idx == 10'(BUS_STAT_IDX)) begin
            next_prdata = {28'h0, bus_pend};
         end else if (idx == 10'(RX_STAT_IDX)) begin
            next_prdata = {28'h0, rx_pending, 1'b0};
         end else if (idx == 10'(IRQ_STAT_IDX)) begin
            next_prdata = {30'h0, irq_stat};
         end else if (idx == 10'(IRQ_MASK_IDX)) begin
            next_prdata = {30'h0, irq_mask};
         end
      end
   end
   assign prdata = next_prdata;

   ////////////////////////////////////////////////////////////////////
   // checks
   a_rx3_masked: assert property (@(posedge pclk) disable iff (!presetn)
      (!rx_en[3] && rx_terms[2:1] == 2'h0) |=> !rx_irq)
      else $error("masked rx endpoint 3 raised an interrupt");
   a_rx2_passes: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_pending[2] && rx_en[2]) |=> rx_irq)
      else $error("enabled rx endpoint 2 did not raise");
   a_rx1_passes: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_pending[1] && rx_en[1]) |=> irq_req)
      else $error("enabled rx endpoint 1 did not raise");
   a_rx_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rx_en[0] == 1'b0)
      else $error("unused rx enable bit 0 set");
   a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rx_en[7:4] == 4'h0 && bus_en[7:4] == 4'h0)
      else $error("unused upper enable bits set");
   a_frame_masked: assert property (@(posedge pclk) disable iff (!presetn)
      (!bus_en[3] && bus_pend[2:0] == 3'h0) |=> !bus_irq)
      else $error("masked frame start forwarded");
   a_reset_passes: assert property (@(posedge pclk) disable iff (!presetn)
      ((bus_pend[2] && bus_en[2]) || (bus_pend[1] && bus_en[1])) |=> bus_irq)
      else $error("enabled reset or resume not forwarded");
   a_suspend_passes: assert property (@(posedge pclk) disable iff (!presetn)
      (bus_pend[0] && bus_en[0]) |=> bus_irq)
      else $error("enabled suspend not forwarded");
   a_req_or: assert property (@(posedge pclk) disable iff (!presetn)
      irq_req == $past((rx_pending & rx_en[3:1]) != 3'h0
                       || (bus_pend & bus_en[3:0]) != 4'h0))
      else $error("combined request differs from OR");

   ////////////////////////////////////////////////////////////////////
   // register access checks
   sequence s_rx_en_write;
      wr && idx == 10'(RX_EN_IDX);
   endsequence

   sequence s_bus_en_write;
      wr && idx == 10'(BUS_EN_IDX);
   endsequence

   sequence s_quiet_status_read;
      clear_rd && !frame_token && !bus_reset_evt && !resume_evt && !suspend_evt
         && !frame_expected;
   endsequence

   a_rx_en_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_rx_en_write |=> rx_en == ($past(pwdata[7:0]) & RX_EN_WMASK))
      else $error("rx enable write not stored as masked");
   a_bus_en_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_bus_en_write |=> bus_en == ($past(pwdata[7:0]) & BUS_EN_WMASK))
      else $error("bus enable write not stored as masked");
   a_rd_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && (idx == 10'(RX_EN_IDX) || idx == 10'(BUS_EN_IDX)))
      |-> prdata[31:4] == 28'h0)
      else $error("enable read shows upper bits");
   a_rd_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && idx == 10'(RX_EN_IDX)) |-> !prdata[0])
      else $error("rx enable read shows bit 0");
   a_status_read_drop: assert property (@(posedge pclk) disable iff (!presetn)
      s_quiet_status_read |=> ##1 !bus_irq)
      else $error("bus request stayed after status read");
   a_unmapped_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !mapped) |=> $stable(rx_en) && $stable(bus_en) && $stable(irq_mask))
      else $error("unmapped access changed a register");
   a_idle_rdata: assert property (@(posedge pclk) disable iff (!presetn)
      !rd |-> prdata == 32'h0)
      else $error("read data not zero outside reads");
   a_stat_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (rise != 2'h0) |=> (irq_stat & $past(rise)) == $past(rise))
      else $error("rising request not recorded in status");
   a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_mask == 2'h0) |=> !irq)
      else $error("interrupt raised with all sources masked");
endmodule
